// ---- rtl/status_moves.sv ----
// Decoder and executor for status-to-accumulator-and-memory copies
`default_nettype none
`include "status_moves_map.svh"
////////////////////////////////////////////////////////////////////////
module status_moves (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Instruction in execute, one per cycle
	input wire logic i_valid,
	input wire logic [15:0] i_opcode,
	// Data memory read value for page write
	input wire logic [3:0] i_mem_rdata,
	// Hold-release causes
	input wire logic i_release_by_divider,
	input wire logic i_release_by_timer_a,
	input wire logic i_release_by_port_change,
	input wire logic i_release_by_ext_pin,
	input wire logic i_release_by_timer_b,
	input wire logic i_release_by_serial_rx,
	input wire logic i_release_by_serial_tx,
	input wire logic i_cause_clear,
	// Change port pins and serial status
	input wire logic [3:0] i_change_port,
	input wire logic [3:0] i_serial_status_flags,
	// Results
	output status_moves_pkg::nibble_type o_acc,
	output logic o_zero_flag,
	output logic o_mem_we,
	output status_moves_pkg::addr_type o_mem_addr,
	output status_moves_pkg::nibble_type o_mem_wdata,
	output status_moves_pkg::addr_type o_mem_raddr,
	output logic [2:0] o_page_bank,
	output logic [7:0] o_hold_release_cause
);
	import status_moves_pkg::*;

	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		nibble_type acc;
		logic zero;
		logic we;
		addr_type addr;
		nibble_type wdata;
		nibble_type page_register;
		logic [7:0] hold_release_cause;
	} state_type;

	state_type st_q;
	state_type st_d;
	source_type src;
	nibble_type value;
	nibble_type port_change_flags;
	logic page_write;
	logic [7:0] cause_set;

	////////////////////////////////////////////////////////////////////
	change_detect u_change (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_pins(i_change_port),
		.i_clear(i_valid && src == SRC_PORT_CHANGE),
		.o_flags(port_change_flags)
	);

	////////////////////////////////////////////////////////////////////
	// Opcode sits in the top bits; address is always bits 6..0
	always_comb begin
		src = SRC_NONE;
		if (i_opcode[15:6] == `OPC_PAGE_READ) begin
			src = SRC_PAGE;
		end else if (i_opcode[15:7] == `OPC_HOLD_UPPER) begin
			src = SRC_HOLD_UPPER;
		end else if (i_opcode[15:7] == `OPC_HOLD_LOWER) begin
			src = SRC_HOLD_LOWER;
		end else if (i_opcode[15:7] == `OPC_PORT_CHANGE) begin
			src = SRC_PORT_CHANGE;
		end else if (i_opcode[15:7] == `OPC_SERIAL_STAT) begin
			src = SRC_SERIAL;
		end
	end

	assign page_write = i_valid && i_opcode[15:8] == `OPC_PAGE_WRITE;

	always_comb begin
		case (src)
			SRC_HOLD_UPPER: value = st_q.hold_release_cause[7:4];
			SRC_HOLD_LOWER: value = {1'b0, st_q.hold_release_cause[2:0]};
			SRC_PAGE: value = st_q.page_register;
			SRC_PORT_CHANGE: value = port_change_flags;
			SRC_SERIAL: value = i_serial_status_flags;
			default: value = 4'h0;
		endcase
	end

	// Cause bit order: 0 divider, 1 timer A, 2 port, 4 pin, 5..7
	assign cause_set = {i_release_by_serial_tx,
		i_release_by_serial_rx,
		i_release_by_timer_b,
		i_release_by_ext_pin,
		1'b0,
		i_release_by_port_change,
		i_release_by_timer_a,
		i_release_by_divider};

	////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d = st_q;
		st_d.we = 1'b0;
		// A new release event wins over a clear in the same cycle
		if (i_cause_clear) begin
			st_d.hold_release_cause = `CAUSE_RESET;
		end
		st_d.hold_release_cause = st_d.hold_release_cause | cause_set;
		if (i_valid && src != SRC_NONE) begin
			st_d.acc = value;
			st_d.zero = (value == 4'h0);
			st_d.we = 1'b1;
			st_d.addr = i_opcode[6:0];
			st_d.wdata = value;
		end
		if (page_write) begin
			st_d.page_register = i_mem_rdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	assign o_acc = st_q.acc;
	assign o_zero_flag = st_q.zero;
	assign o_mem_we = st_q.we;
	assign o_mem_addr = st_q.addr;
	assign o_mem_wdata = st_q.wdata;
	// Read address is combinational so memory answers in the same cycle
	assign o_mem_raddr = i_opcode[6:0];
	assign o_page_bank = st_q.page_register[2:0];
	assign o_hold_release_cause = st_q.hold_release_cause;
endmodule // status_moves
`default_nettype wire

// ---- pkg/status_moves_map.svh ----
// Constants for the status readout move decoder
`ifndef STATUS_MOVES_MAP_SVH
`define STATUS_MOVES_MAP_SVH
`define OPC_HOLD_UPPER 9'h093
`define OPC_HOLD_LOWER 9'h092
`define OPC_PAGE_READ 10'h17F
`define OPC_PORT_CHANGE 9'h09E
`define OPC_SERIAL_STAT 9'h0BE
`define OPC_PAGE_WRITE 8'h5D
`define ACC_RESET 4'h0
`define PAGE_RESET 4'h0
`define CAUSE_RESET 8'h00
`define CHANGE_RESET 4'h0
`define PAGE_BANK_LSB 0
`define PAGE_BANK_W 3
`endif

// ---- pkg/status_moves_pkg.sv ----
// Types for the status readout move decoder
`default_nettype none
package status_moves_pkg;
	typedef logic [3:0] nibble_type;
	typedef logic [6:0] addr_type;
	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_HOLD_UPPER,
		SRC_HOLD_LOWER,
		SRC_PAGE,
		SRC_PORT_CHANGE,
		SRC_SERIAL
	} source_type;
endpackage
`default_nettype wire

// ---- rtl/change_detect.sv ----
// Synchroniser and sticky change flags for the change port
`default_nettype none
`include "status_moves_map.svh"
module change_detect (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Pins and clear
	input wire logic [3:0] i_pins,
	input wire logic i_clear,
	// Flags
	output logic [3:0] o_flags
);
	import status_moves_pkg::*;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] flags;
	} state_type;

	state_type st_q;
	state_type st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = i_pins;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// Set beats clear so a change in the read cycle is kept
		if (i_clear) begin
			st_d.flags = `CHANGE_RESET;
		end
		st_d.flags = st_d.flags | (st_q.s2 ^ st_q.s3);
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			// Pipe keeps sampling in reset so idle-high pins make no false edge
			st_q <= st_d;
			st_q.flags <= `CHANGE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Flags start at zero after reset; s2 and s3 keep sampling the pins in reset and are not zeroed
	assign o_flags = st_q.flags;
endmodule // change_detect
`default_nettype wire

// ---- dv/status_moves_properties.sv ----
// Checker for the status readout moves
`default_nettype none
module status_moves_properties (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_valid,
	input wire logic [15:0] i_opcode,
	input wire logic [3:0] i_serial_status_flags,
	input wire logic [3:0] o_acc,
	input wire logic o_zero_flag,
	input wire logic o_mem_we,
	input wire logic [6:0] o_mem_addr,
	input wire logic [3:0] o_mem_wdata,
	input wire logic [6:0] o_mem_raddr,
	input wire logic [2:0] o_page_bank,
	input wire logic [7:0] o_hold_release_cause
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// Short names keep each property on few lines
	wire logic go = i_valid;
	wire logic [8:0] pfx = i_opcode[15:7];
	wire logic [3:0] hi = o_hold_release_cause[7:4];
	wire logic [3:0] lo = o_hold_release_cause[3:0];
	chk_upper_copy: assert property (
		go && pfx == 9'h093 |=> o_acc == $past(hi)) else $error("upper");
	chk_lower_copy: assert property (
		go && pfx == 9'h092 |=> o_acc == $past(lo)) else $error("lower");
	chk_page_copy: assert property (
		go && i_opcode[15:6] == 10'h17F |=> o_acc[2:0] == $past(o_page_bank))
		else $error("page");
	chk_serial_copy: assert property (
		go && pfx == 9'h0BE |=> o_mem_we && o_mem_addr == $past(o_mem_raddr)
		&& o_acc == $past(i_serial_status_flags)) else $error("serial");
	chk_zero_flag: assert property (
		o_mem_we |-> o_zero_flag == (o_acc == 4'h0)) else $error("zero");
	chk_reserved_zero: assert property (
		!o_hold_release_cause[3]) else $error("reserved");
	chk_idle_no_write: assert property (
		!go |=> !o_mem_we) else $error("stray write");
	chk_write_data: assert property (
		o_mem_we |-> o_mem_wdata == o_acc) else $error("wdata");
	chk_port_write: assert property (
		go && pfx == 9'h09E |=> o_mem_we && o_mem_addr == $past(o_mem_raddr))
		else $error("port copy");
	cover property (o_mem_we && o_zero_flag);
	cover property (o_mem_we && !o_zero_flag);
	cover property (o_hold_release_cause != 8'h00);
endmodule // status_moves_properties
////////////////////////////////////////////////////////////////////////
bind status_moves status_moves_properties i_props (.*);
`default_nettype wire

// ---- dv/status_moves_tb_top.sv ----
// Self-checking bench for the status readout moves
`default_nettype none
module status_moves_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, valid = 0, clr = 0;
	logic [15:0] opc = 16'h0000;
	logic [3:0] rdata = 4'h0, pins = 4'h0, ser = 4'h0, acc;
	logic [6:0] rel = 7'h00, addr, raddr;
	logic [3:0] wdata;
	logic [2:0] bank;
	logic [7:0] cause;
	logic zf, we;
	int n_mismatch = 0, samples_checked = 0;
	status_moves i_dut (.i_clk(clk), .i_rstn(rstn), .i_valid(valid),
		.i_opcode(opc), .i_mem_rdata(rdata),
		.i_release_by_divider(rel[0]), .i_release_by_timer_a(rel[1]),
		.i_release_by_port_change(rel[2]), .i_release_by_ext_pin(rel[3]),
		.i_release_by_timer_b(rel[4]), .i_release_by_serial_rx(rel[5]),
		.i_release_by_serial_tx(rel[6]), .i_cause_clear(clr),
		.i_change_port(pins), .i_serial_status_flags(ser), .o_acc(acc),
		.o_zero_flag(zf), .o_mem_we(we), .o_mem_addr(addr),
		.o_mem_wdata(wdata), .o_mem_raddr(raddr), .o_page_bank(bank),
		.o_hold_release_cause(cause));
	////////////////////////////////////////////////////////////////////
	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// One instruction, judged one cycle later
	task automatic run(logic [15:0] op, logic [3:0] exp);
		opc = op;
		valid = 1;
		@(negedge clk);
		valid = 0;
		check("acc", 8'(exp), 8'(acc));
		check("zero", 8'(exp == 4'h0), 8'(zf));
		check("we", 8'h01, 8'(we));
		check("addr", 8'(op[6:0]), 8'(addr));
		check("wdata", 8'(exp), 8'(wdata));
		check("raddr", 8'(op[6:0]), 8'(raddr));
		// Idle cycle so valid is never lowered and raised in one step
		@(negedge clk);
		check("we idle", 8'h00, 8'(we));
	endtask
	task automatic t_cause();
		rel = 7'h55;
		@(negedge clk);
		rel = 7'h00;
		check("cause", 8'hA5, cause);
		run(16'h4991, 4'hA);
		run(16'h4922, 4'h5);
		clr = 1;
		@(negedge clk);
		clr = 0;
		run(16'h49FF, 4'h0);
		rel = 7'h2A;
		@(negedge clk);
		rel = 7'h00;
		run(16'h4980, 4'h5);
		run(16'h4900, 4'h2);
	endtask
	task automatic t_page();
		rdata = 4'hD;
		opc = 16'h5D05;
		valid = 1;
		@(negedge clk);
		valid = 0;
		@(negedge clk);
		check("bank", 8'h05, 8'(bank));
		run(16'h5FC5, 4'hD);
	endtask
	// Sync pipe needs a few cycles before the flag shows
	task automatic t_change();
		pins = 4'h4;
		repeat (4) @(negedge clk);
		run(16'h4F00, 4'h4);
		run(16'h4F01, 4'h0);
	endtask
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		#10us;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(negedge clk);
		rstn = 1;
		@(negedge clk);
		check("cause", 8'h00, cause);
		ser = 4'hA;
		run(16'h5F15, 4'hA);
		ser = 4'h0;
		run(16'h5F7F, 4'h0);
		t_cause();
		t_page();
		t_change();
		tally_and_finish();
	end
endmodule // status_moves_tb_top
`default_nettype wire
